// ===== src/pmirc_cfg.svh
// Constants for the port MAC and ingress rate control block.
// Assumes byte-wide registers on a plain address/strobe port.
// Function
// - storm bit enables broadcast storm protection
// - back pressure only half duplex, when enabled
// - full duplex uses separately enabled PAUSE
// - drop CRC error, oversize, undersize frames
// - pass-all forwards bad frames to mirror only
// - pass-all leaves flow control filtering alone
// - select port based or priority based limiting
// - select packet count or bit count mode
// - assert flow control when rate exceeded
// - rate flow control needs port flow control
// - limit mode picks counted frame classes
// - IFG counting adds twelve bytes per frame in bit count mode
// - preamble counting adds eight bytes per frame
// - preamble option ignored in packet mode
// - priority codes apply on priority seven write
`ifndef PMIRC_CFG_SVH
`define PMIRC_CFG_SVH
`define PMIRC_AW          12
`define PMIRC_OFS_CTRL_A  12'h400
`define PMIRC_OFS_CTRL_B  12'h401
`define PMIRC_OFS_IRL     12'h403
`define PMIRC_OFS_STAT    12'h404
`define PMIRC_OFS_PRIO0   12'h410
`define PMIRC_OFS_PRIO7   12'h417
`define PMIRC_A_STORM     1
`define PMIRC_A_WMASK     8'h0b
`define PMIRC_B_PASSALL   0
`define PMIRC_B_BP        3
`define PMIRC_B_WMASK     8'hbf
`define PMIRC_IRL_WMASK   8'h7f
`define PMIRC_IRL_PORT    6
`define PMIRC_IRL_PPS     5
`define PMIRC_IRL_FC      4
`define PMIRC_IRL_LIM_HI  3
`define PMIRC_IRL_LIM_LO  2
`define PMIRC_IRL_IFG     1
`define PMIRC_IRL_PRE     0
`define PMIRC_PRIO_WMASK  8'h7f
`define PMIRC_RST_VAL     8'h00
`define PMIRC_IFG_BYTES   8'h0c
`define PMIRC_PRE_BYTES   8'h08
`define PMIRC_CLK_MHZ     250
`define PMIRC_TICK_NS     1000
`define PMIRC_TICK_CYC    (`PMIRC_TICK_NS * `PMIRC_CLK_MHZ / 1000)
`define PMIRC_STORM_US    50
`define PMIRC_STORM_CYC   (`PMIRC_STORM_US * `PMIRC_CLK_MHZ)
`endif

// ===== src/pmirc_pkg.sv
// Types for the port MAC and ingress rate control block.
// Assumes the constants header is included by users alongside.
package pmirc_pkg;
	// frame summary delivered once per frame at its end
	typedef struct packed {
		logic        valid;
		logic [13:0] len;
		logic        crc_err;
		logic        bcast;
		logic        mcast;
		logic        flood;
		logic        fc_frame;
		logic [2:0]  prio;
	} pmirc_frame_t;
	// verdict handed to the forwarding engine
	typedef struct packed {
		logic valid;
		logic fwd;
		logic mirror;
		logic drop;
	} pmirc_verdict_t;
	typedef enum logic [1:0] {
		PMIRC_LIM_ALL,
		PMIRC_LIM_BMF,
		PMIRC_LIM_BM,
		PMIRC_LIM_B
	} pmirc_lim_t;
	typedef enum {
		PMIRC_T_RUN,
		PMIRC_T_TICK
	} pmirc_tick_t;
endpackage

// ===== src/pmirc_top.sv
// Port MAC control and ingress rate limiter for one switch port.
// Assumes frame summaries arrive synchronous to i_ref_clk.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "pmirc_cfg.svh"
module pmirc_top
	import pmirc_pkg::*;
#(
	parameter int PRIO_N    = 8,
	parameter int MAX_LEN   = 1522,
	parameter int MIN_LEN   = 64,
	parameter int PKT_COST  = 521,
	parameter int BURST     = 65535,
	parameter int STORM_MAX = 64,
	parameter int TICK_CYC  = `PMIRC_TICK_CYC,
	parameter int STORM_CYC = `PMIRC_STORM_CYC
) (
	input  wire logic               i_ref_clk,
	input  wire logic               i_rst_b,
	input  wire logic [`PMIRC_AW-1:0] i_addr,
	input  wire logic [7:0]         i_wdata,
	input  wire logic               i_wr,
	input  wire logic               i_rd,
	output logic [7:0]              o_rdata_q,
	input  wire pmirc_frame_t       i_frm,
	input  wire logic               i_full_duplex,
	input  wire logic               i_port_fc_en,
	input  wire logic               i_pause_en,
	input  wire logic               i_fc_filter,
	input  wire logic               i_congest,
	output pmirc_verdict_t          o_verdict_q,
	output logic                    o_pause_q,
	output logic                    o_bp_q,
	output logic                    o_storm_en_q
);
	localparam int CW = 24;
	localparam logic signed [CW-1:0] CMAX = CW'(BURST);

	generate
		if (PRIO_N != 8 || MIN_LEN > MAX_LEN || TICK_CYC < 1 ||
		    STORM_CYC < 1 || BURST >= (1 << (CW - 2))) begin : g_chk
			$error("pmirc_top: unsupported parameter values");
		end
	endgenerate

	logic [7:0] ctrl_a_q;
	logic [7:0] ctrl_b_q;
	logic [7:0] irl_q;
	logic [6:0] stage_q [PRIO_N];
	logic [6:0] code_q  [PRIO_N];
	logic signed [CW-1:0] credit_q [PRIO_N];
	logic [PRIO_N-1:0] over_d;
	logic [31:0] tick_cnt_q;
	logic [31:0] storm_win_q;
	logic [15:0] storm_cnt_q;
	pmirc_tick_t tick_st_q;

	// decoded control fields
	logic       port_based;
	logic       pps_mode;
	logic       rate_fc;
	pmirc_lim_t lim_mode;
	logic       cnt_ifg;
	logic       cnt_pre;
	assign port_based = irl_q[`PMIRC_IRL_PORT];
	assign pps_mode   = irl_q[`PMIRC_IRL_PPS];
	assign rate_fc    = irl_q[`PMIRC_IRL_FC];
	assign lim_mode   = pmirc_lim_t'(irl_q[`PMIRC_IRL_LIM_HI:`PMIRC_IRL_LIM_LO]);
	assign cnt_ifg    = irl_q[`PMIRC_IRL_IFG];
	assign cnt_pre    = irl_q[`PMIRC_IRL_PRE];

	// class match for the counted frame kinds
	function automatic logic counted(input pmirc_lim_t m,
	                                 input pmirc_frame_t f);
		logic r;
		r = 1'b0;
		case (m)
			PMIRC_LIM_ALL: r = 1'b1;
			PMIRC_LIM_BMF: r = f.bcast | f.mcast | f.flood;
			PMIRC_LIM_BM:  r = f.bcast | f.mcast;
			PMIRC_LIM_B:   r = f.bcast;
			default:       r = 1'b0;
		endcase
		return r;
	endfunction

	wire is_wr_a  = i_wr && (i_addr == `PMIRC_OFS_CTRL_A);
	wire is_wr_b  = i_wr && (i_addr == `PMIRC_OFS_CTRL_B);
	wire is_wr_rl = i_wr && (i_addr == `PMIRC_OFS_IRL);
	wire is_wr_p7 = i_wr && (i_addr == `PMIRC_OFS_PRIO7);

	// control registers; reserved r/w bits are kept but unused
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ctrl_a_q <= `PMIRC_RST_VAL;
			ctrl_b_q <= `PMIRC_RST_VAL;
			irl_q    <= `PMIRC_RST_VAL;
		end else begin
			if (is_wr_a)
				ctrl_a_q <= i_wdata & `PMIRC_A_WMASK;
			if (is_wr_b)
				ctrl_b_q <= i_wdata & `PMIRC_B_WMASK;
			if (is_wr_rl)
				irl_q <= i_wdata & `PMIRC_IRL_WMASK;
		end
	end

	// staged codes go live together so limits never mix old and new
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int i = 0; i < PRIO_N; i++) begin
				stage_q[i] <= 7'h00;
				code_q[i]  <= 7'h00;
			end
		end else begin
			for (int i = 0; i < PRIO_N; i++) begin
				if (i_wr && i_addr == `PMIRC_OFS_PRIO0 + 12'(i))
					stage_q[i] <= i_wdata[6:0];
			end
			if (is_wr_p7) begin
				for (int i = 0; i < PRIO_N - 1; i++)
					code_q[i] <= stage_q[i];
				code_q[PRIO_N-1] <= i_wdata[6:0];
			end
		end
	end

	// bucket state, one bit per priority
	always_comb begin
		for (int i = 0; i < PRIO_N; i++)
			over_d[i] = (code_q[i] != 7'h00) &&
			            (credit_q[i] <= 0);
	end

	// read port; unmapped addresses return zero
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rdata_q <= 8'h00;
		end else if (i_rd) begin
			o_rdata_q <= 8'h00;
			case (i_addr)
				`PMIRC_OFS_CTRL_A: o_rdata_q <= ctrl_a_q;
				`PMIRC_OFS_CTRL_B: o_rdata_q <= ctrl_b_q;
				`PMIRC_OFS_IRL:    o_rdata_q <= irl_q;
				`PMIRC_OFS_STAT:   o_rdata_q <= 8'(over_d);
				default: begin
					for (int i = 0; i < PRIO_N; i++)
						if (i_addr == `PMIRC_OFS_PRIO0 + 12'(i))
							o_rdata_q <= {1'b0, stage_q[i]};
				end
			endcase
		end else begin
			o_rdata_q <= 8'h00;
		end
	end

	// refill tick; the time base is shared by every bucket
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tick_cnt_q <= 32'h0;
			tick_st_q  <= PMIRC_T_RUN;
		end else begin
			case (tick_st_q)
				PMIRC_T_RUN: begin
					if (tick_cnt_q == 32'(TICK_CYC - 1)) begin
						tick_cnt_q <= 32'h0;
						tick_st_q  <= PMIRC_T_TICK;
					end else begin
						tick_cnt_q <= tick_cnt_q + 32'h1;
					end
				end
				PMIRC_T_TICK: begin
					tick_cnt_q <= tick_cnt_q + 32'h1;
					tick_st_q  <= PMIRC_T_RUN;
				end
				default: tick_st_q <= PMIRC_T_RUN;
			endcase
		end
	end
	wire tick = (tick_st_q == PMIRC_T_TICK);

	// per-frame classification
	wire        bad  = i_frm.crc_err ||
	                   (32'(i_frm.len) > 32'(MAX_LEN)) ||
	                   (32'(i_frm.len) < 32'(MIN_LEN));
	wire [2:0]  bsel = port_based ? 3'h0 : i_frm.prio;
	wire        cnt  = counted(lim_mode, i_frm);
	wire        lim  = cnt && over_d[bsel];
	wire        fc_on = rate_fc && i_port_fc_en;
	wire        fc_req = fc_on && (|over_d);
	wire        storm_hit = ctrl_a_q[`PMIRC_A_STORM] && i_frm.bcast &&
	                        (32'(storm_cnt_q) >= 32'(STORM_MAX));

	// frame cost: packet units or bits with optional overhead
	logic [CW-1:0] cost;
	always_comb begin
		cost = CW'({i_frm.len, 3'b000});
		if (cnt_ifg)
			cost = cost + CW'({`PMIRC_IFG_BYTES, 3'b000});
		if (cnt_pre)
			cost = cost + CW'({`PMIRC_PRE_BYTES, 3'b000});
		if (pps_mode)
			cost = CW'(PKT_COST);
	end

	// buckets refill each tick and pay for every counted good frame
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int i = 0; i < PRIO_N; i++)
				credit_q[i] <= CMAX;
		end else begin
			for (int i = 0; i < PRIO_N; i++) begin
				logic signed [CW-1:0] c;
				c = credit_q[i];
				if (tick)
					c = c + $signed(CW'(code_q[i]));
				if (code_q[i] == 7'h00 || c > CMAX)
					c = CMAX;
				if (i_frm.valid && !bad && cnt && bsel == 3'(i))
					c = c - $signed(cost);
				credit_q[i] <= c;
			end
		end
	end

	// broadcast storm window counter
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			storm_win_q <= 32'h0;
			storm_cnt_q <= 16'h0;
		end else if (storm_win_q == 32'(STORM_CYC - 1)) begin
			storm_win_q <= 32'h0;
			storm_cnt_q <= 16'h0;
		end else begin
			storm_win_q <= storm_win_q + 32'h1;
			if (i_frm.valid && i_frm.bcast && !bad &&
			    storm_cnt_q != 16'hffff)
				storm_cnt_q <= storm_cnt_q + 16'h1;
		end
	end

	// verdict toward the forwarding engine
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_verdict_q <= '0;
		end else begin
			o_verdict_q <= '0;
			o_verdict_q.valid <= i_frm.valid;
			if (i_frm.valid) begin
				if (i_frm.fc_frame && i_fc_filter) begin
					o_verdict_q.drop <= 1'b1;
				end else if (bad) begin
					if (ctrl_b_q[`PMIRC_B_PASSALL])
						o_verdict_q.mirror <= 1'b1;
					else
						o_verdict_q.drop <= 1'b1;
				end else if (storm_hit || (lim && !fc_on)) begin
					o_verdict_q.drop <= 1'b1;
				end else begin
					o_verdict_q.fwd <= 1'b1;
				end
			end
		end
	end

	// flow control toward the link partner, per duplex
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_pause_q    <= 1'b0;
			o_bp_q       <= 1'b0;
			o_storm_en_q <= 1'b0;
		end else begin
			o_pause_q <= i_full_duplex && i_pause_en &&
			             (i_congest || fc_req);
			o_bp_q    <= !i_full_duplex && ctrl_b_q[`PMIRC_B_BP] &&
			             (i_congest || fc_req);
			o_storm_en_q <= ctrl_a_q[`PMIRC_A_STORM];
		end
	end

	a_bp_half_only: assert property (@(posedge i_ref_clk)
		disable iff (!i_rst_b)
		o_bp_q |-> $past(!i_full_duplex && ctrl_b_q[`PMIRC_B_BP]))
		else $error("back pressure outside half duplex");
	a_pause_full: assert property (@(posedge i_ref_clk)
		disable iff (!i_rst_b)
		o_pause_q |-> $past(i_full_duplex && i_pause_en))
		else $error("pause outside full duplex");
	a_bad_dropped: assert property (@(posedge i_ref_clk)
		disable iff (!i_rst_b)
		(i_frm.valid && bad && !ctrl_b_q[`PMIRC_B_PASSALL]) |=>
		o_verdict_q.drop)
		else $error("bad frame not dropped");
	a_pass_mirror: assert property (@(posedge i_ref_clk)
		disable iff (!i_rst_b)
		(i_frm.valid && bad && ctrl_b_q[`PMIRC_B_PASSALL] &&
		!i_frm.fc_frame) |=> (o_verdict_q.mirror && !o_verdict_q.fwd))
		else $error("pass-all frame not mirror only");
	a_fc_filter: assert property (@(posedge i_ref_clk)
		disable iff (!i_rst_b)
		(i_frm.valid && i_frm.fc_frame && i_fc_filter) |=>
		(o_verdict_q.drop && !o_verdict_q.mirror))
		else $error("flow control frame escaped filter");
	a_rate_fc_gate: assert property (@(posedge i_ref_clk)
		disable iff (!i_rst_b)
		(!i_congest && !(rate_fc && i_port_fc_en)) |=>
		(!o_pause_q && !o_bp_q))
		else $error("rate flow control without port enable");
	// the check looks one edge past the staging write's own commit slot
	a_code_commit: assert property (@(posedge i_ref_clk)
		disable iff (!i_rst_b)
		(i_wr && i_addr == `PMIRC_OFS_PRIO0) ##1 !is_wr_p7 |=>
		$stable(code_q[0]))
		else $error("priority code applied early");
	a_pps_cost: assert property (@(posedge i_ref_clk)
		disable iff (!i_rst_b)
		pps_mode |-> cost == CW'(PKT_COST))
		else $error("packet mode cost not fixed");
	a_ifg_cost: assert property (@(posedge i_ref_clk)
		disable iff (!i_rst_b)
		(!pps_mode && cnt_ifg && !cnt_pre) |->
		cost == CW'({i_frm.len, 3'b000}) + CW'(96))
		else $error("ifg bytes not added");
	a_pre_cost: assert property (@(posedge i_ref_clk)
		disable iff (!i_rst_b)
		(!pps_mode && !cnt_ifg && cnt_pre) |->
		cost == CW'({i_frm.len, 3'b000}) + CW'({`PMIRC_PRE_BYTES, 3'b000}))
		else $error("preamble bytes not added");
	a_storm_drop: assert property (@(posedge i_ref_clk)
		disable iff (!i_rst_b)
		(i_frm.valid && storm_hit && !bad && !i_frm.fc_frame) |=>
		o_verdict_q.drop)
		else $error("storm frame not dropped");
	// with rate flow control in effect an over-limit frame still passes
	a_fc_keeps_fwd: assert property (@(posedge i_ref_clk)
		disable iff (!i_rst_b)
		(i_frm.valid && !bad && !i_frm.fc_frame && !storm_hit &&
		lim && fc_on) |=> o_verdict_q.fwd)
		else $error("rate limited frame dropped under flow control");
	a_verdict_one: assert property (@(posedge i_ref_clk)
		disable iff (!i_rst_b)
		o_verdict_q.valid |->
		$onehot({o_verdict_q.fwd, o_verdict_q.mirror, o_verdict_q.drop}))
		else $error("verdict not exactly one action");
	a_read_zero: assert property (@(posedge i_ref_clk)
		disable iff (!i_rst_b)
		!i_rd |=> o_rdata_q == 8'h00)
		else $error("read data outside read slot");
endmodule

// ===== tb/pmirc_partner.sv
// Link partner model: hands the design one frame summary per request.
// Assumes requests change just after the rising edge of i_ref_clk.
`timescale 1ns/1ps
module pmirc_partner
	import pmirc_pkg::*;
(
	input  wire logic         i_ref_clk,
	input  wire logic         i_go,
	input  wire pmirc_frame_t i_f,
	output pmirc_frame_t      o_frm
);
	initial o_frm = '0;
	// idle cycles scramble the fields so stale values never look valid
	always @(posedge i_ref_clk) begin
		if (i_go)
			o_frm <= i_f;
		else
			o_frm <= {1'b0, ~o_frm[21:0]};
	end
endmodule

// ===== tb/test_pmirc_top.sv
// Testbench for the port MAC control and ingress rate limiter.
// Assumes the design sources and the partner model compile first.
`timescale 1ns/1ps
`include "pmirc_cfg.svh"
module test_pmirc_top
	import pmirc_pkg::*;
;
	localparam logic [3:0] FWD = 4'b1100;
	localparam logic [3:0] MIR = 4'b1010;
	localparam logic [3:0] DRP = 4'b1001;
	logic           clk = 0, rst_b = 0, wr = 0, rd = 0, go = 0;
	logic           full = 0, pfc = 0, pen = 0, filt = 1, cong = 0;
	logic [11:0]    addr = '0;
	logic [7:0]     wd = '0, rdat, s = 8'h19;
	pmirc_frame_t   fc = '0, frm;
	pmirc_verdict_t vd;
	logic           pause, bp, storm, rp = 0, vp = 0;
	logic [7:0]     rq[$];
	logic [3:0]     vq[$];
	int             bad_count = 0, n_tests = 0, sd = 0;

	initial forever #2 clk = ~clk;

	// short tick, window and bucket so limits bite within a few frames
	pmirc_top #(.PKT_COST(100), .BURST(560), .STORM_MAX(2),
		.TICK_CYC(4), .STORM_CYC(20)) dut_u (
		.i_ref_clk(clk), .i_rst_b(rst_b), .i_addr(addr),
		.i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata_q(rdat),
		.i_frm(frm), .i_full_duplex(full), .i_port_fc_en(pfc),
		.i_pause_en(pen), .i_fc_filter(filt), .i_congest(cong),
		.o_verdict_q(vd), .o_pause_q(pause), .o_bp_q(bp),
		.o_storm_en_q(storm));
	pmirc_partner lp_u (.i_ref_clk(clk), .i_go(go), .i_f(fc), .o_frm(frm));

	task chk(input string nm, input logic [7:0] seen, input logic [7:0] ex);
		n_tests++;
		if (seen !== ex) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, seen);
		end
	endtask

	function logic [7:0] lf(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction

	function pmirc_frame_t mk(input logic [13:0] l, input logic c,
		input logic [2:0] k, input logic f, input logic [2:0] p);
		return {1'b1, l, c, k, f, p};
	endfunction

	// results show the cycle after their cause; negedge avoids edge races
	always @(negedge clk) begin
		if (rp)
			chk("rdata", rdat, rq.pop_front());
		if (vp && vq.size() != 0)
			chk("verdict", {4'h0, vd}, {4'h0, vq.pop_front()});
		else if (vp && vd.drop === 1'b1)
			sd++;
		rp = rd;
		vp = frm.valid;
	end

	task bw(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task br(input logic [11:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		rq.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask
	task wm(input logic [11:0] a, input logic [7:0] m);
		s = lf(s);
		bw(a, s);
		br(a, s & m);
	endtask
	// a zero expectation means the verdict is not compared
	task send(input pmirc_frame_t f, input logic [3:0] e);
		@(posedge clk);
		go <= 1'b1;
		fc <= f;
		if (e != 4'h0)
			vq.push_back(e);
	endtask
	task idle(input int n);
		@(posedge clk);
		go <= 1'b0;
		repeat (n) @(posedge clk);
	endtask
	// fresh reset, prio 0 code 1 staged (committed only if cm), one frame, then the over-limit status
	task trial(input logic [7:0] irl, input logic [2:0] k,
		input logic [2:0] p, input logic [13:0] l, input logic cm,
		input logic [7:0] ex);
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		br(`PMIRC_OFS_IRL, 8'h00);
		bw(`PMIRC_OFS_PRIO0, 8'h01);
		if (cm)
			bw(`PMIRC_OFS_PRIO7, 8'h00);
		bw(`PMIRC_OFS_IRL, irl);
		send(mk(l, 1'b0, k, 1'b0, p), FWD);
		idle(3);
		br(`PMIRC_OFS_STAT, ex);
	endtask

	task complete_run;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge clk);
		bad_count++;
		complete_run();
	end

	initial begin
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		br(`PMIRC_OFS_CTRL_A, 8'h00);
		br(`PMIRC_OFS_CTRL_B, 8'h00);
		s = lf(s);
		send(mk(14'(s) * 14'd5 + 14'd64, 0, 3'h0, 0, 3'd0), FWD);
		send(mk(14'd100, 1, 3'h0, 0, 3'd0), DRP);
		send(mk(14'd1523, 0, 3'h0, 0, 3'd0), DRP);
		send(mk(14'd63, 0, 3'h0, 0, 3'd0), DRP);
		idle(2);
		bw(`PMIRC_OFS_CTRL_B, 8'h01);
		send(mk(14'd100, 1, 3'h0, 0, 3'd0), MIR);
		send(mk(14'd1523, 0, 3'h0, 0, 3'd0), MIR);
		send(mk(14'd64, 0, 3'h0, 1, 3'd0), DRP);
		send(mk(14'd64, 0, 3'h0, 0, 3'd0), FWD);
		idle(3);
		wm(`PMIRC_OFS_CTRL_A, `PMIRC_A_WMASK);
		wm(`PMIRC_OFS_CTRL_B, `PMIRC_B_WMASK);
		wm(`PMIRC_OFS_IRL, `PMIRC_IRL_WMASK);
		br(12'h402, 8'h00);
		cong <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			full <= i[0];
			pen <= i[1];
			bw(`PMIRC_OFS_CTRL_B, {4'h0, i[2], 3'h0});
			repeat (2) @(negedge clk);
			chk("bp", {7'h0, bp}, {7'h0, ~i[0] & i[2]});
			chk("pause", {7'h0, pause}, {7'h0, i[0] & i[1]});
		end
		@(posedge clk);
		cong <= 1'b0;
		// storm bit clear: broadcast bursts must pass untouched
		bw(`PMIRC_OFS_CTRL_A, 8'h00);
		repeat (6) send(mk(14'd64, 0, 3'b100, 0, 3'd0), FWD);
		idle(2);
		bw(`PMIRC_OFS_CTRL_A, 8'h02);
		repeat (2) @(negedge clk);
		chk("storm en", {7'h0, storm}, 8'h01);
		repeat (6) send(mk(14'd64, 0, 3'b100, 0, 3'd0), 4'h0);
		idle(3);
		chk("storm drop", {7'h0, sd != 0}, 8'h01);
		trial(8'h00, 3'h0, 3'd0, 14'd66, 1, 8'h00);
		trial(8'h01, 3'h0, 3'd0, 14'd66, 1, 8'h01);
		trial(8'h01, 3'h0, 3'd0, 14'd66, 0, 8'h00);
		trial(8'h02, 3'h0, 3'd0, 14'd66, 1, 8'h01);
		trial(8'h00, 3'h0, 3'd0, 14'd80, 1, 8'h01);
		trial(8'h20, 3'h0, 3'd0, 14'd80, 1, 8'h00);
		trial(8'h21, 3'h0, 3'd0, 14'd66, 1, 8'h00);
		trial(8'h05, 3'b001, 3'd0, 14'd66, 1, 8'h01);
		trial(8'h05, 3'b000, 3'd0, 14'd66, 1, 8'h00);
		trial(8'h09, 3'b010, 3'd0, 14'd66, 1, 8'h01);
		trial(8'h09, 3'b001, 3'd0, 14'd66, 1, 8'h00);
		trial(8'h0d, 3'b100, 3'd0, 14'd66, 1, 8'h01);
		trial(8'h0d, 3'b010, 3'd0, 14'd66, 1, 8'h00);
		trial(8'h41, 3'h0, 3'd3, 14'd66, 1, 8'h01);
		trial(8'h01, 3'h0, 3'd3, 14'd66, 1, 8'h00);
		trial(8'h11, 3'h0, 3'd0, 14'd66, 1, 8'h01);
		full <= 1'b1;
		pen <= 1'b1;
		pfc <= 1'b1;
		repeat (2) @(negedge clk);
		chk("rate pause", {7'h0, pause}, 8'h01);
		send(mk(14'd66, 0, 3'h0, 0, 3'd0), FWD);
		idle(1);
		pfc <= 1'b0;
		repeat (2) @(negedge clk);
		chk("rate pause", {7'h0, pause}, 8'h00);
		send(mk(14'd66, 0, 3'h0, 0, 3'd0), DRP);
		idle(3);
		complete_run();
	end
endmodule
